//--- inc/pfcsb_pkg.sv
// pfcsb_pkg: constants, encodings and types of the compare/skip/branch unit
package pfcsb_pkg;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
  localparam logic EXEC_EN_RST = 1'b1;

  // ****************************************************************
  // status flag positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // ****************************************************************
  // apb register byte offsets and field positions
  // ****************************************************************
  localparam logic [7:0] ADDR_PC = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_INFO = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam int INFO_SKIP_POS = 8;
  localparam int INFO_BRANCH_POS = 9;

  // ****************************************************************
  // cycle counts
  // ****************************************************************
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ****************************************************************
  // opcode patterns: a word matches when (word & mask) == value; the indirect call word is compared whole
  // ****************************************************************
  localparam logic [15:0] OP_POINTER_INDIRECT_SUBROUTINE_CALL = 16'h9509;
  localparam logic [15:0] MASK_RR = 16'hfc00;
  localparam logic [15:0] OP_COMPARE_SKIP_ON_EQUAL = 16'h1000;
  localparam logic [15:0] OP_CP = 16'h1400;
  localparam logic [15:0] OP_CPC = 16'h0400;
  localparam logic [15:0] MASK_IMM = 16'hf000;
  localparam logic [15:0] OP_CPI = 16'h3000;
  localparam logic [15:0] MASK_RBIT = 16'hfe08;
  localparam logic [15:0] OP_SKIP_ON_REG_BIT_LOW = 16'hfc00;
  localparam logic [15:0] OP_SKIP_ON_REG_BIT_HIGH = 16'hfe00;
  localparam logic [15:0] MASK_IOBIT = 16'hff00;
  localparam logic [15:0] OP_SKIP_ON_IO_BIT_LOW = 16'h9900;
  localparam logic [15:0] OP_SKIP_ON_IO_BIT_HIGH = 16'h9b00;
  localparam logic [15:0] OP_BRANCH_ON_FLAG_HIGH = 16'hf000;
  localparam logic [15:0] OP_BRANCH_ON_FLAG_LOW = 16'hf400;
  // two-word instruction families, seen when a skip crosses them
  localparam logic [15:0] MASK_LONG_JC = 16'hfe0c;
  localparam logic [15:0] OP_LONG_JC = 16'h940c;
  localparam logic [15:0] MASK_LONG_LS = 16'hfc0f;
  localparam logic [15:0] OP_LONG_LS = 16'h9000;

  // ****************************************************************
  // instruction classes
  // ****************************************************************
  typedef enum logic [3:0] {
    cls_other = 4'h0,
    cls_pointer_indirect_subroutine_call = 4'h1,
    cls_compare_skip_on_equal = 4'h2,
    cls_register_compare = 4'h3,
    cls_register_compare_with_borrow = 4'h4,
    cls_immediate_compare = 4'h5,
    cls_skip_on_reg_bit_low = 4'h6,
    cls_skip_on_reg_bit_high = 4'h7,
    cls_skip_on_io_bit_low = 4'h8,
    cls_skip_on_io_bit_high = 4'h9,
    cls_branch_on_flag_high = 4'ha,
    cls_branch_on_flag_low = 4'hb
  } pfcsb_cls_t;

  // execution states, gray along issue -> stall -> issue
  typedef enum logic {
    st_issue = 1'b0,
    st_stall = 1'b1
  } pfcsb_state_t;

endpackage : pfcsb_pkg

//--- inc/pfcsb_dec_if.sv
// pfcsb_dec_if: decoded instruction fields between decoder and executor
interface pfcsb_dec_if;
  logic [15:0] word;
  logic [15:0] next_word;
  pfcsb_pkg::pfcsb_cls_t cls;
  logic [2:0] bit_idx;
  logic [6:0] offset;
  logic [7:0] imm;
  logic next_two;

  // decoder side
  modport dec (
    input word,
    input next_word,
    output cls,
    output bit_idx,
    output offset,
    output imm,
    output next_two
  );

  // executor side
  modport exe (
    output word,
    output next_word,
    input cls,
    input bit_idx,
    input offset,
    input imm,
    input next_two
  );
endinterface : pfcsb_dec_if

//--- hdl/pfcsb_decode.sv
// pfcsb_decode: combinational decode of the control-flow instruction words
module pfcsb_decode (
  // decoded fields
  pfcsb_dec_if.dec dif
);

  // pattern test, used for every opcode family but the indirect call, which is an exact word compare
  function automatic logic op_match(input logic [15:0] w,
                                    input logic [15:0] mask,
                                    input logic [15:0] val);
    op_match = ((w & mask) == val);
  endfunction

  // ****************************************************************
  // class decode
  // ****************************************************************
  always_comb begin
    dif.cls = pfcsb_pkg::cls_other;
    if (dif.word == pfcsb_pkg::OP_POINTER_INDIRECT_SUBROUTINE_CALL) begin
      dif.cls = pfcsb_pkg::cls_pointer_indirect_subroutine_call;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RR,
                          pfcsb_pkg::OP_COMPARE_SKIP_ON_EQUAL)) begin
      dif.cls = pfcsb_pkg::cls_compare_skip_on_equal;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RR,
                          pfcsb_pkg::OP_CP)) begin
      dif.cls = pfcsb_pkg::cls_register_compare;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RR,
                          pfcsb_pkg::OP_CPC)) begin
      dif.cls = pfcsb_pkg::cls_register_compare_with_borrow;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_IMM,
                          pfcsb_pkg::OP_CPI)) begin
      dif.cls = pfcsb_pkg::cls_immediate_compare;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RBIT,
                          pfcsb_pkg::OP_SKIP_ON_REG_BIT_LOW)) begin
      dif.cls = pfcsb_pkg::cls_skip_on_reg_bit_low;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RBIT,
                          pfcsb_pkg::OP_SKIP_ON_REG_BIT_HIGH)) begin
      dif.cls = pfcsb_pkg::cls_skip_on_reg_bit_high;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_IOBIT,
                          pfcsb_pkg::OP_SKIP_ON_IO_BIT_LOW)) begin
      dif.cls = pfcsb_pkg::cls_skip_on_io_bit_low;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_IOBIT,
                          pfcsb_pkg::OP_SKIP_ON_IO_BIT_HIGH)) begin
      dif.cls = pfcsb_pkg::cls_skip_on_io_bit_high;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RR,
                          pfcsb_pkg::OP_BRANCH_ON_FLAG_HIGH)) begin
      dif.cls = pfcsb_pkg::cls_branch_on_flag_high;
    end else if (op_match(dif.word, pfcsb_pkg::MASK_RR,
                          pfcsb_pkg::OP_BRANCH_ON_FLAG_LOW)) begin
      dif.cls = pfcsb_pkg::cls_branch_on_flag_low;
    end
  end

  // ****************************************************************
  // operand fields
  // ****************************************************************
  // bit index doubles as the flag index of the flag branches
  assign dif.bit_idx = dif.word[2:0];
  assign dif.offset = dif.word[9:3];
  assign dif.imm = {dif.word[11:8], dif.word[3:0]};
  // length of the word a skip would step over
  assign dif.next_two = op_match(dif.next_word, pfcsb_pkg::MASK_LONG_JC,
                                 pfcsb_pkg::OP_LONG_JC)
                      | op_match(dif.next_word, pfcsb_pkg::MASK_LONG_LS,
                                 pfcsb_pkg::OP_LONG_LS);

endmodule // pfcsb_decode

//--- hdl/pfcsb_exec.sv
// pfcsb_exec: compare, skip, branch and indirect call execution unit
// Operation
// - indirect call loads pc from z pointer, flags kept, three cycles
// - compare two registers, skip next when equal; 1 cycle, 2/3 on skip
// - compares subtract reg, reg plus carry or immediate; set Z N V C H
// - skip next when selected register bit is zero, flags kept
// - skip next when selected register bit is one, flags kept
// - skip next when selected io register bit reads zero
// - skip next when selected io register bit reads one
// - flag-selected branch when flag is one: pc+k+1, 1 or 2 cycles
// - flag-selected branch when flag is zero: pc+k+1, 1 or 2 cycles
// - branch on equal taken when zero flag is one
// - branch on unequal taken when zero flag is zero
// - branch on carry high taken when carry is one
// - branch on carry low taken when carry is zero
// - unsigned same-or-higher branch behaves as carry-low branch
//
// Design decisions made here: the register offsets and register access over APB.
module pfcsb_exec (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // instruction issue from fetch/decode
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] next_word_i,
  // operand values read for the presented instruction
  input wire logic [7:0] rd_val_i,
  input wire logic [7:0] rr_val_i,
  input wire logic [7:0] io_val_i,
  input wire logic [15:0] z_ptr_i,
  // execution results
  output logic ready_o,
  output logic [15:0] pc_o,
  output logic [7:0] status_flags_register_o,
  output logic call_push_o,
  output logic [15:0] ret_addr_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pfcsb_pkg::pfcsb_state_t st;
    logic [1:0] remain;
    logic ready;
    logic [15:0] pc;
    logic [7:0] status_flags_register;
    logic push;
    logic [15:0] ret;
    logic [1:0] last_cyc;
    logic last_skip;
    logic last_branch;
    logic en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pfcsb_regs_t;

  pfcsb_regs_t s;
  pfcsb_regs_t next_s;

  pfcsb_dec_if dif ();

  pfcsb_decode u_decode (
    .dif(dif)
  );
  assign dif.word = instr_i;
  assign dif.next_word = next_word_i;

  logic issue;
  logic apb_wr;
  logic wr_pc;
  logic wr_flags;
  logic [15:0] pc_inc;
  logic [15:0] off_ext;
  logic [15:0] skip_tgt;
  logic [1:0] skip_cyc;
  logic [7:0] cmp_b;
  logic cmp_cin;
  logic [8:0] diff;
  logic [7:0] res;
  logic sel_flag;
  logic sel_rbit;
  logic sel_iobit;
  logic mapped;

  assign issue = instr_valid_i & s.ready;
  // writes land at the access edge with pready high
  assign apb_wr = psel_i & penable_i & pwrite_i & s.pready;
  assign wr_pc = apb_wr & (paddr_i == pfcsb_pkg::ADDR_PC);
  assign wr_flags = apb_wr & (paddr_i == pfcsb_pkg::ADDR_FLAGS);

  // ****************************************************************
  // datapath
  // ****************************************************************
  assign pc_inc = s.pc + 16'h0001;
  assign off_ext = {{9{dif.offset[6]}}, dif.offset};
  assign skip_tgt = dif.next_two ? (s.pc + 16'h0003) : (s.pc + 16'h0002);
  assign skip_cyc = dif.next_two ? pfcsb_pkg::CYC_THREE : pfcsb_pkg::CYC_TWO;
  assign sel_flag = s.status_flags_register[dif.bit_idx];
  assign sel_rbit = rr_val_i[dif.bit_idx];
  assign sel_iobit = io_val_i[dif.bit_idx];

  // subtraction without writeback, borrow for the carry form
  assign cmp_b = (dif.cls == pfcsb_pkg::cls_immediate_compare) ?
                 dif.imm : rr_val_i;
  assign cmp_cin = (dif.cls == pfcsb_pkg::cls_register_compare_with_borrow)
                 & s.status_flags_register[pfcsb_pkg::FLAG_C];
  assign diff = {1'b0, rd_val_i} - {1'b0, cmp_b} - {8'h00, cmp_cin};
  assign res = diff[7:0];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.push = 1'b0;
    // stall countdown; a multi-cycle instruction holds off the next issue
    unique case (s.st)
      pfcsb_pkg::st_issue: begin
        next_s.ready = s.en;
      end
      pfcsb_pkg::st_stall: begin
        if (s.remain == 2'h0) begin
          next_s.st = pfcsb_pkg::st_issue;
          next_s.ready = s.en;
        end else begin
          next_s.remain = s.remain - 2'h1;
        end
      end
    endcase
    if (issue) begin
      next_s.pc = pc_inc;
      next_s.last_cyc = pfcsb_pkg::CYC_ONE;
      next_s.last_skip = 1'b0;
      next_s.last_branch = 1'b0;
      unique case (dif.cls)
        pfcsb_pkg::cls_pointer_indirect_subroutine_call: begin
          // jump through z, push return address
          next_s.pc = z_ptr_i;
          next_s.push = 1'b1;
          next_s.ret = pc_inc;
          next_s.last_cyc = pfcsb_pkg::CYC_THREE;
          next_s.last_branch = 1'b1;
        end
        pfcsb_pkg::cls_compare_skip_on_equal: begin
          if (rd_val_i == rr_val_i) begin
            next_s.pc = skip_tgt;
            next_s.last_cyc = skip_cyc;
            next_s.last_skip = 1'b1;
          end
        end
        pfcsb_pkg::cls_register_compare,
        pfcsb_pkg::cls_register_compare_with_borrow,
        pfcsb_pkg::cls_immediate_compare: begin
          // flag update; zero is sticky for the borrow form
          next_s.status_flags_register[pfcsb_pkg::FLAG_Z] = (res == 8'h00) &
            ((dif.cls != pfcsb_pkg::cls_register_compare_with_borrow) |
             s.status_flags_register[pfcsb_pkg::FLAG_Z]);
          next_s.status_flags_register[pfcsb_pkg::FLAG_N] = res[7];
          next_s.status_flags_register[pfcsb_pkg::FLAG_V] =
            (rd_val_i[7] & ~cmp_b[7] & ~res[7]) |
            (~rd_val_i[7] & cmp_b[7] & res[7]);
          next_s.status_flags_register[pfcsb_pkg::FLAG_C] =
            (~rd_val_i[7] & cmp_b[7]) | (cmp_b[7] & res[7]) |
            (res[7] & ~rd_val_i[7]);
          next_s.status_flags_register[pfcsb_pkg::FLAG_H] =
            (~rd_val_i[3] & cmp_b[3]) | (cmp_b[3] & res[3]) |
            (res[3] & ~rd_val_i[3]);
        end
        pfcsb_pkg::cls_skip_on_reg_bit_low,
        pfcsb_pkg::cls_skip_on_reg_bit_high: begin
          if (sel_rbit ==
              (dif.cls == pfcsb_pkg::cls_skip_on_reg_bit_high)) begin
            next_s.pc = skip_tgt;
            next_s.last_cyc = skip_cyc;
            next_s.last_skip = 1'b1;
          end
        end
        pfcsb_pkg::cls_skip_on_io_bit_low,
        pfcsb_pkg::cls_skip_on_io_bit_high: begin
          if (sel_iobit ==
              (dif.cls == pfcsb_pkg::cls_skip_on_io_bit_high)) begin
            next_s.pc = skip_tgt;
            next_s.last_cyc = skip_cyc;
            next_s.last_skip = 1'b1;
          end
        end
        pfcsb_pkg::cls_branch_on_flag_high,
        pfcsb_pkg::cls_branch_on_flag_low: begin
          if (sel_flag ==
              (dif.cls == pfcsb_pkg::cls_branch_on_flag_high)) begin
            next_s.pc = pc_inc + off_ext;
            next_s.last_cyc = pfcsb_pkg::CYC_TWO;
            next_s.last_branch = 1'b1;
          end
        end
        default: next_s.pc = pc_inc; // other words advance by one
      endcase
      if (next_s.last_cyc != pfcsb_pkg::CYC_ONE) begin
        next_s.st = pfcsb_pkg::st_stall;
        next_s.ready = 1'b0;
        next_s.remain = next_s.last_cyc - 2'h2;
      end
    end
    // software loads win over execution in the same edge
    if (wr_pc) begin
      next_s.pc = pwdata_i[15:0];
    end
    if (wr_flags) begin
      next_s.status_flags_register = pwdata_i[7:0];
    end
    if (apb_wr & (paddr_i == pfcsb_pkg::ADDR_CTRL)) begin
      next_s.en = pwdata_i[0];
    end
    if (~next_s.en) begin
      next_s.ready = 1'b0;
    end
    // apb answers one cycle after setup, read data captured at setup
    next_s.pready = psel_i & ~penable_i;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0000_0000;
    if (psel_i & ~penable_i) begin
      next_s.pslverr = ~mapped;
      unique case (paddr_i)
        pfcsb_pkg::ADDR_PC: next_s.prdata = {16'h0000, s.pc};
        pfcsb_pkg::ADDR_FLAGS: next_s.prdata = {24'h00_0000, s.status_flags_register};
        pfcsb_pkg::ADDR_INFO: begin
          next_s.prdata[1:0] = s.last_cyc;
          next_s.prdata[pfcsb_pkg::INFO_SKIP_POS] = s.last_skip;
          next_s.prdata[pfcsb_pkg::INFO_BRANCH_POS] = s.last_branch;
        end
        pfcsb_pkg::ADDR_CTRL: next_s.prdata = {31'h0000_0000, s.en};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
  end

  assign mapped = (paddr_i == pfcsb_pkg::ADDR_PC) |
                  (paddr_i == pfcsb_pkg::ADDR_FLAGS) |
                  (paddr_i == pfcsb_pkg::ADDR_INFO) |
                  (paddr_i == pfcsb_pkg::ADDR_CTRL);

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.pc <= pfcsb_pkg::PC_RST;
      s.status_flags_register <= pfcsb_pkg::STATUS_FLAGS_REGISTER_RST;
      s.en <= pfcsb_pkg::EXEC_EN_RST;
      s.st <= pfcsb_pkg::st_issue;
      s.last_cyc <= pfcsb_pkg::CYC_ONE;
    end else begin
      s <= next_s;
    end
  end

  assign ready_o = s.ready;
  assign pc_o = s.pc;
  assign status_flags_register_o = s.status_flags_register;
  assign call_push_o = s.push;
  assign ret_addr_o = s.ret;
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic clean;
  assign clean = issue & ~wr_pc & ~wr_flags;

  sequence s_hold_two;
    !ready_o ##1 !ready_o;
  endsequence

  sequence s_hold_one;
    !ready_o ##1 1'b1;
  endsequence

  property p_pointer_indirect_subroutine_call;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_pointer_indirect_subroutine_call
    |=> pc_o == $past(z_ptr_i) && status_flags_register_o == $past(status_flags_register_o)
        && call_push_o ##0 s_hold_two;
  endproperty
  a_pointer_indirect_subroutine_call: assert property (p_pointer_indirect_subroutine_call)
    else $error("indirect call target or timing wrong");
  property p_compare_skip_on_equal;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_compare_skip_on_equal
    && rd_val_i == rr_val_i && !dif.next_two
    |=> pc_o == $past(s.pc) + 16'h0002 ##0 s_hold_one;
  endproperty
  a_compare_skip_on_equal: assert property (p_compare_skip_on_equal)
    else $error("equal skip did not step two words");
  property p_cmp_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_register_compare
    |=> status_flags_register_o[pfcsb_pkg::FLAG_Z] == ($past(rd_val_i) == $past(rr_val_i))
        && status_flags_register_o[pfcsb_pkg::FLAG_C] == ($past(rd_val_i) < $past(rr_val_i))
        && ready_o;
  endproperty
  a_cmp_zero: assert property (p_cmp_zero)
    else $error("compare flags wrong");
  property p_skip_on_reg_bit_low;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_skip_on_reg_bit_low && sel_rbit
    |=> pc_o == $past(s.pc) + 16'h0001 && ready_o;
  endproperty
  a_skip_on_reg_bit_low: assert property (p_skip_on_reg_bit_low)
    else $error("register bit skip taken on a set bit");
  property p_skip_on_io_bit_high;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_skip_on_io_bit_high && sel_iobit
    && dif.next_two
    |=> pc_o == $past(s.pc) + 16'h0003 ##0 s_hold_two ##1 ready_o;
  endproperty
  a_skip_on_io_bit_high: assert property (p_skip_on_io_bit_high)
    else $error("io bit skip over long word wrong");
  property p_branch_on_flag_high;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_branch_on_flag_high && sel_flag
    |=> pc_o == $past(s.pc) + 16'h0001 + $past(off_ext)
        ##0 s_hold_one ##0 ready_o;
  endproperty
  a_branch_on_flag_high: assert property (p_branch_on_flag_high)
    else $error("flag branch target wrong");
  property p_branch_on_flag_low_fall;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_branch_on_flag_low && sel_flag
    |=> pc_o == $past(s.pc) + 16'h0001 && status_flags_register_o == $past(status_flags_register_o);
  endproperty
  a_branch_on_flag_low_fall: assert property (p_branch_on_flag_low_fall)
    else $error("clear-flag branch taken on set flag");
  property p_back_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clean && dif.cls == pfcsb_pkg::cls_branch_on_flag_low && !sel_flag
    && dif.offset == 7'h7f
    |=> pc_o == $past(s.pc);
  endproperty
  a_back_off: assert property (p_back_off)
    else $error("negative offset not sign extended");
  property p_apb_wait;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer late");

endmodule // pfcsb_exec

//--- verification/pfcsb_exec_test.sv
// pfcsb_exec_test: random self-checking bench of the exec unit
module pfcsb_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // bench signals and model state
  // ****************************************
  logic ref_clk_i, rst_n_i, instr_valid_i, psel_i, penable_i, pwrite_i;
  logic [15:0] instr_i, next_word_i, z_ptr_i, pc_o, ret_addr_o, pc;
  logic [7:0] rd_val_i, rr_val_i, io_val_i, status_flags_register_o, paddr_i, sf;
  logic [31:0] pwdata_i, prdata_o, r;
  logic ready_o, call_push_o, pready_o, pslverr_o, e;
  int mismatches = 0;
  int check_count = 0;
  int seed = 49;

  pfcsb_exec dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .next_word_i(next_word_i), .rd_val_i(rd_val_i), .rr_val_i(rr_val_i),
    .io_val_i(io_val_i), .z_ptr_i(z_ptr_i), .ready_o(ready_o),
    .pc_o(pc_o), .status_flags_register_o(status_flags_register_o), .call_push_o(call_push_o),
    .ret_addr_o(ret_addr_o), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

  // free-running core clock, 50 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // compare flags: result discarded, borrow chain gives c and h
  function automatic logic [7:0] cmpf(input logic [7:0] s, x, y,
                                      input logic ci, kz);
    logic [7:0] q;
    logic [7:0] f;
    q = x - y - ci;
    f = s;
    f[0] = (~x[7] & y[7]) | (y[7] & q[7]) | (q[7] & ~x[7]);
    f[5] = (~x[3] & y[3]) | (y[3] & q[3]) | (q[3] & ~x[3]);
    f[3] = (x[7] & ~y[7] & ~q[7]) | (~x[7] & y[7] & q[7]);
    f[2] = q[7];
    f[1] = (q == 8'h00) & (kz ? s[1] : 1'b1);
    return f;
  endfunction

  task automatic chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // apb transfer; pready, prdata, pslverr taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // no cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // issue one word, then count cycles until ready comes back
  task automatic issue(input logic [15:0] w, ep, input logic [1:0] n,
                       input logic cp);
    int c;
    instr_i <= w;
    instr_valid_i <= 1'b1;
    c = 0;
    do begin
      @(posedge ref_clk_i);
      c++;
    end while (ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    #1;
    chk(pc_o, ep);
    chk(status_flags_register_o, sf);
    chk(call_push_o, cp);
    c = 1;
    @(posedge ref_clk_i);
    while (ready_o !== 1'b1 && c < 8) begin
      c++;
      @(posedge ref_clk_i);
    end
    chk(c, n);
  endtask

  // main sequence: reset values, then random mix of every class but cls_other
  initial begin
    logic [15:0] w, ep, zz;
    logic [7:0] a, b;
    logic [6:0] k;
    logic [2:0] bi;
    logic two, sk, br;
    logic [1:0] n;
    {instr_valid_i, psel_i, penable_i, pwrite_i} = 4'h0;
    {instr_i, next_word_i, z_ptr_i} = 48'h0;
    {rd_val_i, rr_val_i, io_val_i, paddr_i} = 32'h0;
    pwdata_i = 32'h0;
    rst_n_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    pc = 16'h0000;
    sf = 8'h00;
    apb(1'b0, pfcsb_pkg::ADDR_PC, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, pfcsb_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    // the info word is read-only: a write must leave it alone
    apb(1'b1, pfcsb_pkg::ADDR_INFO, 32'hffff_ffff);
    apb(1'b0, pfcsb_pkg::ADDR_INFO, 32'h0);
    chk(r, 32'h1);
    for (int i = 0; i < 330; i++) begin
      if (i % 4 == 0) begin
        pc = $random(seed);
        sf = $random(seed);
        apb(1'b1, pfcsb_pkg::ADDR_PC, {16'h0, pc});
        apb(1'b1, pfcsb_pkg::ADDR_FLAGS, {24'h0, sf});
      end
      a = $random(seed);
      b = $random(seed);
      if (a[0]) b = a;
      bi = $random(seed);
      k = $random(seed);
      two = $random(seed);
      zz = $random(seed);
      rd_val_i <= a;
      rr_val_i <= b;
      io_val_i <= b;
      z_ptr_i <= zz;
      next_word_i <= two ? (k[0] ? 16'h940c : 16'h9000) : 16'h0000;
      sk = 1'b0;
      br = 1'b0;
      case (i % 11)
        0: begin w = 16'h1400; sf = cmpf(sf, a, b, 1'b0, 1'b0); end
        1: begin w = 16'h0400; sf = cmpf(sf, a, b, sf[0], 1'b1); end
        2: begin
          w = {4'h3, b[7:4], 4'h0, b[3:0]};
          sf = cmpf(sf, a, b, 1'b0, 1'b0);
        end
        3: begin w = 16'h1000; sk = (a == b); end
        4: begin w = {13'h1f80, bi}; sk = !b[bi]; end
        5: begin w = {13'h1fc0, bi}; sk = b[bi]; end
        6: begin w = {8'h99, a[4:0], bi}; sk = !b[bi]; end
        7: begin w = {8'h9b, a[4:0], bi}; sk = b[bi]; end
        8: begin w = {6'h3c, k, bi}; br = sf[bi]; end
        9: begin
          // early rounds: offset -1, a taken branch lands on itself
          if (i < 100) k = 7'h7f;
          w = {6'h3d, k, bi};
          br = !sf[bi];
        end
        default: begin w = 16'h9509; br = 1'b1; end
      endcase
      n = sk ? 2'h2 + two : (br ? 2'h2 : 2'h1);
      ep = sk ? pc + 16'h2 + two : pc + 16'h1;
      if (br) ep = pc + 16'h1 + {{9{k[6]}}, k};
      if (i % 11 == 10) begin
        ep = zz;
        n = 2'h3;
      end
      issue(w, ep, n, i % 11 == 10);
      if (i % 11 == 10) chk(ret_addr_o, pc + 16'h1);
      apb(1'b0, pfcsb_pkg::ADDR_INFO, 32'h0);
      chk(r, {22'h0, br, sk, 6'h0, n});
      pc = ep;
    end
    apb(1'b0, pfcsb_pkg::ADDR_FLAGS, 32'h0);
    chk(r, {24'h0, sf});
    apb(1'b1, pfcsb_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk(ready_o, 1'b0);
    finish_test();
  end

  // watchdog: the run needs well under a millisecond
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule // pfcsb_exec_test
